// ===== hw/qur_pkg.sv
// Purpose: shared constants and types for the four-channel serial block
// Assumes: one 50 MHz core clock
// Notes: register indices are per channel, three address bits
package qur_pkg;
    // =====================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_MIN_NS = 40;
    localparam int RST_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RST_CNT_LAST = 2'(RST_MIN_CYC - 1);
    // =====================================================
    // sizes
    localparam int NUM_CHAN = 4;
    localparam int CHAN_C_INDEX = 2;
    localparam int FIFO_DEPTH = 64;
    localparam logic [6:0] FIFO_FULL_COUNT = 7'h40;
    localparam logic [6:0] RTS_THRESHOLD = 7'h38;
    // =====================================================
    // register indices
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_DIV_LO = 3'h1;
    localparam logic [2:0] REG_DIV_HI = 3'h2;
    localparam logic [2:0] REG_CONFIG = 3'h3;
    localparam logic [2:0] REG_MODEM = 3'h4;
    localparam logic [2:0] REG_LINE = 3'h5;
    localparam logic [2:0] REG_XON = 3'h6;
    localparam logic [2:0] REG_XOFF = 3'h7;
    // =====================================================
    // fields
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_INT_EN_BIT = 3;
    localparam int MCR_ANY_RESUME_BIT = 5;
    localparam int MCR_PRESCALE_BIT = 7;
    localparam int CFG_HWFLOW_BIT = 4;
    localparam int CFG_SWFLOW_BIT = 5;
    localparam int CFG_RXIRQ_BIT = 6;
    localparam int CFG_TXIRQ_BIT = 7;
    localparam int LSR_RX_VALID = 0;
    localparam int LSR_OVERRUN = 1;
    localparam int LSR_FRAMING = 3;
    localparam int LSR_HALTED = 4;
    localparam int LSR_TX_ROOM = 5;
    localparam int LSR_TX_IDLE = 6;
    // =====================================================
    // reset values
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] XON_RESET = 8'h11;
    localparam logic [7:0] XOFF_RESET = 8'h13;
    // =====================================================
    // bit timing, four samples per bit
    localparam logic [1:0] PHASE_MID = 2'h1;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} qur_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} qur_rx_state_t;
endpackage

// ===== hw/qur_fifo_if.sv
// Purpose: carrier between a channel and one of its byte queues
// Assumes: single clock
// Notes: read data is one cycle stale after a pop, see rd_valid
`timescale 1ns/1ps
`default_nettype none
interface qur_fifo_if;
    logic push;
    logic pop;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic full;
    logic rd_valid;
    logic [6:0] count;
    modport store(input push, pop, wr_data, output rd_data, full, rd_valid, count);
    modport user(output push, pop, wr_data, input rd_data, full, rd_valid, count);
endinterface
`default_nettype wire

// ===== hw/qur_fifo.sv
// Purpose: 64-byte queue with registered read data
// Assumes: reset synchronous, active high
// Notes: push when full and pop when not valid are ignored
`timescale 1ns/1ps
`default_nettype none
module qur_fifo import qur_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    qur_fifo_if.store port
);
    logic [7:0] mem [FIFO_DEPTH];
    logic [5:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [6:0] count_q, count_d;
    logic valid_q, valid_d;
    logic [7:0] data_q;
    logic do_push, do_pop;

    assign port.full = (count_q == FIFO_FULL_COUNT);
    assign port.count = count_q;
    assign port.rd_valid = valid_q;
    assign port.rd_data = data_q;
    assign do_push = port.push && !port.full;
    assign do_pop = port.pop && valid_q;

    always_comb begin
        wr_ptr_d = do_push ? wr_ptr_q + 6'h01 : wr_ptr_q;
        rd_ptr_d = do_pop ? rd_ptr_q + 6'h01 : rd_ptr_q;
        count_d = count_q + {6'h00, do_push} - {6'h00, do_pop};
        // valid waits one cycle so data_q has caught up with the pointer
        valid_d = (count_q != 7'h00) && !do_pop;
        if (rst_in) begin
            wr_ptr_d = 6'h00;
            rd_ptr_d = 6'h00;
            count_d = 7'h00;
            valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        wr_ptr_q <= wr_ptr_d;
        rd_ptr_q <= rd_ptr_d;
        count_q <= count_d;
        valid_q <= valid_d;
    end

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem[wr_ptr_q] <= port.wr_data;
        end
        data_q <= mem[rd_ptr_q];
    end
endmodule
`default_nettype wire

// ===== hw/qur_baud.sv
// Purpose: prescaler plus fractional divisor giving a 4x sample tick
// Assumes: src_en_in is a one-cycle enable from the clock source
// Notes: divisor zero stops the tick
`timescale 1ns/1ps
`default_nettype none
module qur_baud import qur_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic src_en_in,
    input wire logic div4_in,
    input wire logic [15:0] divisor_in,
    input wire logic [3:0] frac_in,
    output logic tick_out
);
    logic [1:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d, limit;
    logic [3:0] acc_q, acc_d;
    logic extra_q, extra_d, tick_q, tick_d, pre_en;
    logic [4:0] acc_sum;

    assign tick_out = tick_q;

    always_comb begin
        pre_d = src_en_in ? pre_q + 2'h1 : pre_q;
        pre_en = src_en_in && (!div4_in || pre_q == PHASE_LAST);
        limit = divisor_in - 16'h0001 + {15'h0000, extra_q};
        acc_sum = {1'b0, acc_q} + {1'b0, frac_in};
        cnt_d = cnt_q;
        acc_d = acc_q;
        extra_d = extra_q;
        tick_d = 1'b0;
        if (pre_en && divisor_in != 16'h0000) begin
            if (cnt_q >= limit) begin
                // fraction spreads extra counts over sixteen periods
                cnt_d = 16'h0000;
                tick_d = 1'b1;
                acc_d = acc_sum[3:0];
                extra_d = acc_sum[4];
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
        if (rst_in) begin
            pre_d = 2'h0;
            cnt_d = 16'h0000;
            acc_d = 4'h0;
            extra_d = 1'b0;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        pre_q <= pre_d;
        cnt_q <= cnt_d;
        acc_q <= acc_d;
        extra_q <= extra_d;
        tick_q <= tick_d;
    end
endmodule
`default_nettype wire

// ===== hw/qur_top.sv
// Purpose: four independent serial channels with queues and flow control
// Assumes: all inputs synchronous to core_clk_in
// Notes: host port is a synchronous strobe port, one read answer per cycle
`timescale 1ns/1ps
`default_nettype none
module qur_top import qur_pkg::*; (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic reset_pin_in,
    input wire logic bus_style_select_in,
    input wire logic interrupt_style_select_in,
    input wire logic prescaler_strap_in,
    input wire logic channel_c_clock_in,
    input wire logic [3:0] host_sel_in,
    input wire logic [2:0] host_addr_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [7:0] host_wdata_in,
    output logic [7:0] host_rdata_out,
    input wire logic [3:0] serial_rx_in,
    output logic [3:0] serial_tx_out,
    output logic [3:0] ir_tx_out,
    input wire logic [3:0] cts_n_in,
    output logic [3:0] rts_n_out,
    output logic [3:0] irq_out,
    output logic [3:0] irq_oe_out,
    output logic [3:0] transmit_room_n_out,
    output logic [3:0] receive_avail_n_out,
    output logic [7:0] fifo_ready_summary_out
);
    // =====================================================
    // reset capture
    logic pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
    logic [1:0] rcnt_q, rcnt_d;
    logic rst_core_q, rst_core_d, pin_active;
    logic cclk_q, cclk_rise;
    logic [7:0] rdata_q, rdata_d, rd_sel;
    logic [7:0] ch_rd [NUM_CHAN];
    logic [3:0] rd_owner, src_en, tx_room_n, rx_avail_n;

    assign pin_active = bus_style_select_in ? reset_pin_in : !reset_pin_in;

    always_comb begin
        pin_s1_d = pin_active;
        pin_s2_d = pin_s1_q;
        rcnt_d = rcnt_q;
        if (!pin_s2_q) begin
            rcnt_d = 2'h0;
        end else if (rcnt_q != RST_CNT_LAST) begin
            rcnt_d = rcnt_q + 2'h1;
        end
        // short glitches on the pin are filtered to the minimum width
        rst_core_d = rst_in || (pin_s2_q && rcnt_q == RST_CNT_LAST);
        if (rst_in) begin
            pin_s1_d = 1'b0;
            pin_s2_d = 1'b0;
            rcnt_d = 2'h0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        pin_s1_q <= pin_s1_d;
        pin_s2_q <= pin_s2_d;
        rcnt_q <= rcnt_d;
        rst_core_q <= rst_core_d;
    end

    // =====================================================
    // host read path and channel C clock
    assign cclk_rise = channel_c_clock_in && !cclk_q;
    assign host_rdata_out = rdata_q;
    assign transmit_room_n_out = tx_room_n;
    assign receive_avail_n_out = rx_avail_n;
    assign fifo_ready_summary_out = {rx_avail_n, tx_room_n};

    always_comb begin
        rd_sel = 8'h00;
        // lowest selected channel answers when several are selected
        for (int k = NUM_CHAN - 1; k >= 0; k--) begin
            if (host_sel_in[k]) begin
                rd_sel = ch_rd[k];
            end
        end
        rdata_d = host_rd_in ? rd_sel : rdata_q;
        if (rst_core_q) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge core_clk_in) begin
        rdata_q <= rdata_d;
        cclk_q <= channel_c_clock_in;
    end

    // =====================================================
    // channels
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_ch
        qur_fifo_if tx_if();
        qur_fifo_if rx_if();
        logic [15:0] div_q, div_d;
        logic [7:0] cfg_q, cfg_d, mcr_q, mcr_d, xon_q, xon_d, xoff_q, xoff_d;
        logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, line_stat;
        logic [1:0] tx_ph_q, tx_ph_d, rx_ph_q, rx_ph_d;
        logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
        qur_tx_state_t tx_st_q, tx_st_d;
        qur_rx_state_t rx_st_q, rx_st_d;
        logic tx_line_q, tx_line_d, ir_q, ir_d, halt_q, halt_d;
        logic ovr_q, ovr_d, frm_q, frm_d, rts_n_q, rts_n_d;
        logic irq_q, irq_d, irq_oe_q, irq_oe_d, room_n_q, room_n_d;
        logic avail_n_q, avail_n_d, tick, wr, rd, can_start, rxd;
        logic char_done, rx_push, lsr_clear;

        assign rd_owner[i] = host_sel_in[i] &&
            ((host_sel_in & ((4'h1 << i) - 4'h1)) == 4'h0);
        assign wr = host_wr_in && host_sel_in[i]; // broadcast writes allowed
        assign rd = host_rd_in && rd_owner[i];
        assign rxd = serial_rx_in[i];
        assign src_en[i] = (i == CHAN_C_INDEX) ? cclk_rise : 1'b1;

        qur_fifo u_txq (.clk_in(core_clk_in), .rst_in(rst_core_q), .port(tx_if.store));
        qur_fifo u_rxq (.clk_in(core_clk_in), .rst_in(rst_core_q), .port(rx_if.store));
        qur_baud u_baud (
            .clk_in(core_clk_in),
            .rst_in(rst_core_q),
            .src_en_in(src_en[i]),
            .div4_in(mcr_q[MCR_PRESCALE_BIT]),
            .divisor_in(div_q),
            .frac_in(cfg_q[3:0]),
            .tick_out(tick)
        );

        assign line_stat = {1'b0, tx_st_q == TX_IDLE && tx_if.count == 7'h00,
            !tx_if.full, halt_q, frm_q, 1'b0, ovr_q, rx_if.rd_valid};
        always_comb begin
            case (host_addr_in)
                REG_DATA: ch_rd[i] = rx_if.rd_valid ? rx_if.rd_data : 8'h00;
                REG_DIV_LO: ch_rd[i] = div_q[7:0];
                REG_DIV_HI: ch_rd[i] = div_q[15:8];
                REG_CONFIG: ch_rd[i] = cfg_q;
                REG_MODEM: ch_rd[i] = mcr_q;
                REG_LINE: ch_rd[i] = line_stat;
                REG_XON: ch_rd[i] = xon_q;
                REG_XOFF: ch_rd[i] = xoff_q;
                default: ch_rd[i] = 8'h00;
            endcase
        end

        assign tx_if.push = wr && host_addr_in == REG_DATA;
        assign tx_if.wr_data = host_wdata_in;
        assign rx_if.pop = rd && host_addr_in == REG_DATA;
        assign lsr_clear = rd && host_addr_in == REG_LINE;
        assign can_start = tx_if.rd_valid && !halt_q &&
            !(cfg_q[CFG_HWFLOW_BIT] && cts_n_in[i]);
        assign tx_if.pop = tick && tx_st_q == TX_IDLE && can_start;
        assign char_done = tick && rx_st_q == RX_STOP && rx_ph_q == PHASE_LAST && rxd;
        // flow characters are consumed, not queued, while software flow is on
        assign rx_push = char_done && !(cfg_q[CFG_SWFLOW_BIT] &&
            (rx_sh_q == xon_q || rx_sh_q == xoff_q));
        assign rx_if.push = rx_push;
        assign rx_if.wr_data = rx_sh_q;

        assign serial_tx_out[i] = tx_line_q;
        assign ir_tx_out[i] = ir_q;
        assign rts_n_out[i] = rts_n_q;
        assign irq_out[i] = irq_q;
        assign irq_oe_out[i] = irq_oe_q;
        assign tx_room_n[i] = room_n_q;
        assign rx_avail_n[i] = avail_n_q;

        always_comb begin
            div_d = div_q;
            cfg_d = cfg_q;
            mcr_d = mcr_q;
            xon_d = xon_q;
            xoff_d = xoff_q;
            if (wr) begin
                case (host_addr_in)
                    REG_DIV_LO: div_d[7:0] = host_wdata_in;
                    REG_DIV_HI: div_d[15:8] = host_wdata_in;
                    REG_CONFIG: cfg_d = host_wdata_in;
                    REG_MODEM: mcr_d = host_wdata_in;
                    REG_XON: xon_d = host_wdata_in;
                    REG_XOFF: xoff_d = host_wdata_in;
                    default: div_d = div_q;
                endcase
            end
            // transmitter, one bit per four ticks
            tx_st_d = tx_st_q;
            tx_ph_d = tx_ph_q;
            tx_bit_d = tx_bit_q;
            tx_sh_d = tx_sh_q;
            tx_line_d = tx_line_q;
            if (tick) begin
                tx_ph_d = tx_ph_q + 2'h1;
                case (tx_st_q)
                    TX_IDLE: begin
                        tx_ph_d = 2'h0;
                        if (can_start) begin
                            tx_st_d = TX_START;
                            tx_sh_d = tx_if.rd_data;
                            tx_line_d = 1'b0;
                        end
                    end
                    TX_START: begin
                        if (tx_ph_q == PHASE_LAST) begin
                            tx_st_d = TX_DATA;
                            tx_bit_d = 3'h0;
                            tx_line_d = tx_sh_q[0];
                        end
                    end
                    TX_DATA: begin
                        if (tx_ph_q == PHASE_LAST) begin
                            tx_sh_d = {1'b1, tx_sh_q[7:1]};
                            tx_bit_d = tx_bit_q + 3'h1;
                            tx_line_d = tx_sh_q[1];
                            if (tx_bit_q == BIT_LAST) begin
                                tx_st_d = TX_STOP;
                                tx_line_d = 1'b1;
                            end
                        end
                    end
                    TX_STOP: begin
                        if (tx_ph_q == PHASE_LAST) begin
                            tx_st_d = TX_IDLE;
                        end
                    end
                    default: tx_st_d = TX_IDLE;
                endcase
            end
            // pulse one quarter of each zero bit
            ir_d = !tx_line_d && tx_ph_d == PHASE_MID;
            // receiver, four samples per bit
            rx_st_d = rx_st_q;
            rx_ph_d = rx_ph_q;
            rx_bit_d = rx_bit_q;
            rx_sh_d = rx_sh_q;
            frm_d = frm_q && !lsr_clear;
            if (tick) begin
                rx_ph_d = rx_ph_q + 2'h1;
                case (rx_st_q)
                    RX_IDLE: begin
                        rx_ph_d = 2'h0;
                        if (!rxd) begin
                            rx_st_d = RX_START;
                        end
                    end
                    RX_START: begin
                        if (rx_ph_q == PHASE_MID) begin
                            rx_ph_d = 2'h0;
                            rx_bit_d = 3'h0;
                            rx_st_d = rxd ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_ph_q == PHASE_LAST) begin
                            rx_sh_d = {rxd, rx_sh_q[7:1]};
                            rx_bit_d = rx_bit_q + 3'h1;
                            if (rx_bit_q == BIT_LAST) begin
                                rx_st_d = RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (rx_ph_q == PHASE_LAST) begin
                            rx_st_d = RX_IDLE;
                            if (!rxd) begin
                                frm_d = 1'b1;
                            end
                        end
                    end
                    default: rx_st_d = RX_IDLE;
                endcase
            end
            // set wins over the read-clear
            ovr_d = (ovr_q && !lsr_clear) || (rx_push && rx_if.full);
            halt_d = halt_q;
            if (char_done && cfg_q[CFG_SWFLOW_BIT]) begin
                if (rx_sh_q == xoff_q) begin
                    halt_d = 1'b1;
                end else if (rx_sh_q == xon_q || mcr_q[MCR_ANY_RESUME_BIT]) begin
                    halt_d = 1'b0;
                end
            end
            if (!cfg_q[CFG_SWFLOW_BIT]) begin
                halt_d = 1'b0;
            end
            rts_n_d = cfg_q[CFG_HWFLOW_BIT] ? (rx_if.count >= RTS_THRESHOLD) :
                !mcr_q[MCR_RTS_BIT];
            irq_d = (rx_if.rd_valid && cfg_q[CFG_RXIRQ_BIT]) ||
                (tx_if.count == 7'h00 && cfg_q[CFG_TXIRQ_BIT]);
            irq_oe_d = !bus_style_select_in || interrupt_style_select_in ||
                mcr_q[MCR_INT_EN_BIT];
            room_n_d = tx_if.full;
            avail_n_d = rx_if.count == 7'h00;
            if (rst_core_q) begin
                div_d = DIV_RESET;
                cfg_d = CFG_RESET;
                mcr_d = MCR_RESET;
                mcr_d[MCR_PRESCALE_BIT] = !prescaler_strap_in;
                xon_d = XON_RESET;
                xoff_d = XOFF_RESET;
                tx_st_d = TX_IDLE;
                tx_ph_d = 2'h0;
                tx_bit_d = 3'h0;
                tx_sh_d = 8'h00;
                tx_line_d = 1'b1;
                ir_d = 1'b0;
                rx_st_d = RX_IDLE;
                rx_ph_d = 2'h0;
                rx_bit_d = 3'h0;
                rx_sh_d = 8'h00;
                frm_d = 1'b0;
                ovr_d = 1'b0;
                halt_d = 1'b0;
                rts_n_d = 1'b1;
                irq_d = 1'b0;
                irq_oe_d = 1'b0;
                room_n_d = 1'b0;
                avail_n_d = 1'b1;
            end
        end

        always_ff @(posedge core_clk_in) begin
            div_q <= div_d;
            cfg_q <= cfg_d;
            mcr_q <= mcr_d;
            xon_q <= xon_d;
            xoff_q <= xoff_d;
            tx_st_q <= tx_st_d;
            tx_ph_q <= tx_ph_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_line_q <= tx_line_d;
            ir_q <= ir_d;
            rx_st_q <= rx_st_d;
            rx_ph_q <= rx_ph_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            frm_q <= frm_d;
            ovr_q <= ovr_d;
            halt_q <= halt_d;
            rts_n_q <= rts_n_d;
            irq_q <= irq_d;
            irq_oe_q <= irq_oe_d;
            room_n_q <= room_n_d;
            avail_n_q <= avail_n_d;
        end
    end
endmodule
`default_nettype wire

// ===== tb/qur_checker.sv
// Purpose: port assertions for qur_top
// Assumes: one clock, rst_in sync active high
// Notes: quiet_q counts cycles with no reset source active
`timescale 1ns/1ps
`default_nettype none
module qur_checker (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic reset_pin_in,
    input wire logic bus_style_select_in,
    input wire logic interrupt_style_select_in,
    input wire logic [3:0] serial_tx_out,
    input wire logic [3:0] ir_tx_out,
    input wire logic [3:0] rts_n_out,
    input wire logic [3:0] irq_oe_out,
    input wire logic [3:0] transmit_room_n_out,
    input wire logic [3:0] receive_avail_n_out,
    input wire logic [7:0] fifo_ready_summary_out
);
    logic [3:0] quiet_q, quiet_d;
    always_comb begin
        quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
        if (rst_in || reset_pin_in == bus_style_select_in) begin
            quiet_d = 4'h0;
        end
    end
    always_ff @(posedge core_clk_in) begin
        quiet_q <= quiet_d;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // ====================================
    // assertions
    AST_SUM_MAP: assert property (
        fifo_ready_summary_out == {receive_avail_n_out, transmit_room_n_out})
        else $error("summary differs from ready flags");
    AST_RST_HI: assert property (
        (bus_style_select_in && reset_pin_in) [*7] |-> serial_tx_out == 4'hf
        && rts_n_out == 4'hf && ir_tx_out == 4'h0 && irq_oe_out == 4'h0)
        else $error("high pin reset");
    AST_RST_LO: assert property (
        (!bus_style_select_in && !reset_pin_in) [*7] |-> serial_tx_out == 4'hf
        && fifo_ready_summary_out == 8'hf0) else $error("low pin reset");
    AST_OE_ON: assert property (
        quiet_q == 4'hf && interrupt_style_select_in && $past(interrupt_style_select_in)
        |-> irq_oe_out == 4'hf) else $error("interrupt not driven");
    AST_OE_STYLE0: assert property (
        quiet_q == 4'hf && !bus_style_select_in && !$past(bus_style_select_in)
        |-> irq_oe_out == 4'hf) else $error("style zero interrupt not driven");
    AST_IR_ZERO: assert property (
        (ir_tx_out & (serial_tx_out | $past(serial_tx_out))) == 4'h0)
        else $error("infrared pulse outside a zero bit");
    AST_START_A: assert property (
        quiet_q == 4'hf && $fell(serial_tx_out[0]) |-> (!serial_tx_out[0]) [*4])
        else $error("channel A start bit short");
    AST_START_C: assert property (
        quiet_q == 4'hf && $fell(serial_tx_out[2]) |-> (!serial_tx_out[2]) [*4])
        else $error("channel C start bit short");
endmodule
bind qur_top qur_checker chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .reset_pin_in(reset_pin_in), .bus_style_select_in(bus_style_select_in),
    .interrupt_style_select_in(interrupt_style_select_in), .serial_tx_out(serial_tx_out),
    .ir_tx_out(ir_tx_out), .rts_n_out(rts_n_out), .irq_oe_out(irq_oe_out),
    .transmit_room_n_out(transmit_room_n_out), .receive_avail_n_out(receive_avail_n_out),
    .fifo_ready_summary_out(fifo_ready_summary_out));
`default_nettype wire

// ===== tb/qur_remote.sv
// Purpose: far-end serial devices that echo each bit back
// Assumes: shares the core clock
// Notes: echo lags one cycle; stall_in holds clear-to-send off
`timescale 1ns/1ps
`default_nettype none
module qur_remote (
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic [3:0] tx_in,
    output logic [3:0] rx_out,
    output logic [3:0] cts_n_out,
    output logic chc_clk_out
);
    initial {rx_out, chc_clk_out} = 5'h1e;
    always @(posedge clk_in) begin
        rx_out <= tx_in;
        chc_clk_out <= !chc_clk_out;
    end
    assign cts_n_out = {4{stall_in}};
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench for qur_top
// Assumes: 50 MHz clock, inputs driven 1 ns after the rising edge
// Notes: read data is checked by the monitor against queued notes
`timescale 1ns/1ps
`default_nettype none
module tb import qur_pkg::*; ;
    logic clk = 1'b0, rst = 1'b1, pin = 1'b0, style = 1'b1, isel = 1'b0, strap = 1'b1;
    logic wr = 1'b0, rd = 1'b0, stall = 1'b0, rd_was = 1'b0, chc;
    logic [3:0] sel = 4'h0, rx, cts_n, tx, ir, rts_n, irq, oe, room_n, avail_n;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, sum, b;
    logic [7:0] exp_q[$];
    int seed = 84, miscompares = 0, n_compared = 0;
    initial forever #10 clk = ~clk;
    qur_top dut (.core_clk_in(clk), .rst_in(rst), .reset_pin_in(pin), .bus_style_select_in(style),
        .interrupt_style_select_in(isel), .prescaler_strap_in(strap), .channel_c_clock_in(chc),
        .host_sel_in(sel), .host_addr_in(addr), .host_wr_in(wr), .host_rd_in(rd),
        .host_wdata_in(wdata), .host_rdata_out(rdata), .serial_rx_in(rx), .serial_tx_out(tx),
        .ir_tx_out(ir), .cts_n_in(cts_n), .rts_n_out(rts_n), .irq_out(irq), .irq_oe_out(oe),
        .transmit_room_n_out(room_n), .receive_avail_n_out(avail_n), .fifo_ready_summary_out(sum));
    qur_remote far (.clk_in(clk), .stall_in(stall), .tx_in(tx), .rx_out(rx), .cts_n_out(cts_n),
        .chc_clk_out(chc));
    // ====================================
    // tasks
    task automatic cmp(string what, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr_reg(logic [3:0] s, logic [2:0] a, logic [7:0] d);
        @(posedge clk) #1 {sel, addr, wdata, wr} = {s, a, d, 1'b1};
        @(posedge clk) #1 wr = 1'b0;
    endtask
    // pops need two cycles between them, so each read idles one edge
    task automatic rd_reg(logic [3:0] s, logic [2:0] a, logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk) #1 {sel, addr, rd} = {s, a, 1'b1};
        @(posedge clk) #1 rd = 1'b0;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd_was) begin
            cmp("host_rdata_out", exp_q.pop_front(), rdata);
        end
        rd_was = rd;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    // ====================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1 cmp("summary", 8'hf0, sum);
        cmp("serial_tx_out", 8'h0f, {4'h0, tx});
        cmp("irq_out", 8'h00, {4'h0, irq});
        rst = 1'b0;
        // let the checker's quiet count fill before channel A sends
        repeat (8) @(posedge clk);
        rd_reg(4'h1, REG_MODEM, 8'h00);
        cmp("irq_oe_out", 8'h00, {4'h0, oe});
        for (int i = 0; i < 4; i++) begin
            b = 8'($random(seed));
            wr_reg(4'(1 << i), REG_DATA, b);
            for (int k = 0; k < 400 && avail_n[i] !== 1'b0; k++) @(posedge clk);
            rd_reg(4'(1 << i), REG_DATA, b);
        end
        wr_reg(4'h2, REG_CONFIG, 8'h20);
        wr_reg(4'h2, REG_DATA, XOFF_RESET);
        repeat (60) @(posedge clk);
        rd_reg(4'h2, REG_LINE, 8'h70);
        wr_reg(4'h1, REG_MODEM, 8'h88);
        rd_reg(4'h1, REG_MODEM, 8'h88);
        cmp("irq_oe_out", 8'h01, {4'h0, oe});
        rd_reg(4'h2, REG_MODEM, 8'h00);
        @(posedge clk) #1 {pin, strap} = 2'b10;
        repeat (8) @(posedge clk);
        #1 pin = 1'b0;
        repeat (8) @(posedge clk);
        rd_reg(4'h2, REG_MODEM, 8'h80);
        @(posedge clk) #1 {pin, style, strap} = 3'b101;
        repeat (20) @(posedge clk);
        #1 pin = 1'b0;
        repeat (8) @(posedge clk);
        #1 pin = 1'b1;
        repeat (8) @(posedge clk);
        rd_reg(4'h1, REG_MODEM, 8'h00);
        @(posedge clk) #1 {pin, style, isel, stall} = 4'b0111;
        wr_reg(4'h8, REG_CONFIG, 8'h10);
        for (int j = 0; j < FIFO_DEPTH; j++) begin
            wr_reg(4'h8, REG_DATA, 8'($random(seed)));
            repeat (2) @(posedge clk);
            if (j >= FIFO_DEPTH - 2) begin
                cmp("room_n", {7'h0, j == FIFO_DEPTH - 1}, {7'h0, room_n[3]});
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
